// ==== src/isoad_pkg.sv ====
// constants for the isolator address decode and loop glue
package isoad_pkg;
    // address windows, compared on the full 16-bit address
    localparam logic [15:0] STATION_ADDR = 16'h0200;
    localparam logic [15:0] LOOP1_LO = 16'h0300;
    localparam logic [15:0] LOOP1_HI = 16'h03ff;
    localparam logic [15:0] LOOP2_LO = 16'h0400;
    localparam logic [15:0] LOOP2_HI = 16'h04ff;
    localparam logic [15:0] LOOP3_LO = 16'h0500;
    localparam logic [15:0] LOOP3_HI = 16'h05ff;
    localparam logic [15:0] BANK1_LO = 16'h2000;
    localparam logic [15:0] BANK1_HI = 16'h3fff;
    localparam logic [15:0] BANK2_LO = 16'h4000;
    localparam logic [15:0] BANK2_HI = 16'h5fff;
    localparam logic [15:0] BANK3_LO = 16'h6000;
    localparam logic [15:0] BANK3_HI = 16'h7fff;
    localparam logic [15:0] ROM_LO = 16'h8000;
    localparam logic [15:0] ROM_HI = 16'hffff;
    // station code field
    localparam int STATION_BITS = 6;
    // loop register select: bit 0 of the address
    localparam int REG_SEL_BIT = 0;
    // timing at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int WATCHDOG_MS = 100;
    localparam int WATCHDOG_CYCLES = WATCHDOG_MS * 1000000 / CLK_PERIOD_NS;
    // shortened strobe: active phase-two cycles skipped at its start
    localparam int SHORT_DELAY_CYCLES = 1;
endpackage : isoad_pkg

// ==== src/isoad_watchdog.sv ====
// retriggerable one-shot that idles the loop 1 transmit line
`timescale 1ns/1ps
`default_nettype none
module isoad_watchdog #(
    parameter int PERIOD_CYCLES = isoad_pkg::WATCHDOG_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // transmit path
    input wire logic tx_data_in,
    output logic tx_data_out,
    output logic timed_out
);
    // state of the one-shot
    typedef struct packed {
        logic [31:0] count;   // cycles left in the period
        logic prev_tx;        // last transmit level, for edge detect
        logic expired;        // forcing term toward idle high
        logic tx_out;         // registered line output
    } isoad_wd_state_t;

    isoad_wd_state_t st_reg;
    isoad_wd_state_t st_next;

    // activity detect: either edge of the transmit line counts as activity
    always_comb
    begin
        st_next = st_reg;
        st_next.prev_tx = tx_data_in;
        if (tx_data_in != st_reg.prev_tx)
        begin
            // any activity retriggers and releases the force
            st_next.count = 32'(PERIOD_CYCLES);
            st_next.expired = 1'b0;
        end
        else if (st_reg.count != 32'h0)
        begin
            st_next.count = st_reg.count - 32'h1;
            if (st_reg.count == 32'h1)
            begin
                st_next.expired = 1'b1;
            end
        end
        // or of port data with the forcing term
        st_next.tx_out = tx_data_in | st_next.expired;
    end

    // register the state; reset lands idle high so a stuck port is safe
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{count: 32'h0, prev_tx: 1'b1, expired: 1'b1,
                        tx_out: 1'b1};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign tx_data_out = st_reg.tx_out;
    assign timed_out = st_reg.expired;

    // once forced, the line stays high until the port moves again;
    // a change in the same cycle releases the force, so it is excluded
    AST_WD_FORCE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (st_reg.expired && tx_data_in == st_reg.prev_tx) |=> tx_data_out)
        else $error("forced idle not seen on transmit output");
    // a quiet line is forced exactly when the period runs out
    AST_WD_EXPIRE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (st_reg.count == 32'h1 && tx_data_in == st_reg.prev_tx) |=>
        timed_out)
        else $error("one-shot did not expire at end of period");
    // with no force, output follows the port
    AST_WD_PASS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!st_next.expired |-> ##1 (tx_data_out == $past(tx_data_in))))
        else $error("transmit data not passed through");
endmodule : isoad_watchdog
`default_nettype wire

// ==== src/isoad_top.sv ====
// address decode, transceiver steering and loop glue of the isolator
// Summary of operation
// - loop one select for 300-3FF
// - loop two select for 400-4FF
// - monitor port select for 500-5FF
// - one RAM bank per 8K window
// - program ROM for 8000-FFFF
// - read at 200 drives station code
// - six switches give codes 00-3F
// - port selects are active low
// - address bit 0 picks data or control
// - transfers complete on phase-two falling edge
// - port raises interrupt on full receiver
// - transceiver direction follows read or write
// - retriggerable 100 ms one-shot on activity
// - expiry forces loop one transmit high
// - resumed traffic passes through OR
// - loops one, two duplex; loop three receive
// - receiver gives 0 when plus below minus
// - short phase-two strobe for early write
`timescale 1ns/1ps
`default_nettype none
module isoad_top #(
    parameter int WATCHDOG_CYCLES = isoad_pkg::WATCHDOG_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // processor bus
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_read_write,
    input wire logic cpu_phase_two,
    input wire logic cpu_valid_addr,
    // station code switches
    input wire logic [5:0] station_switches,
    // selects and steering
    output logic first_loop_select_n,
    output logic second_loop_select_n,
    output logic monitor_port_select_n,
    output logic ram_bank_one_select,
    output logic ram_bank_two_select,
    output logic ram_bank_three_select,
    output logic rom_select,
    output logic station_code_read_enable,
    output logic [7:0] station_data_out,
    output logic station_data_oe,
    output logic xcvr_to_cpu,
    output logic xcvr_enable,
    output logic port_reg_select,
    output logic port_read_write,
    output logic port_enable_strobe,
    output logic short_write_strobe,
    // port interrupts merged for the processor
    input wire logic [2:0] port_irq_n,
    output logic cpu_irq_n,
    // loop serial lines
    input wire logic loop1_port_tx,
    input wire logic loop2_port_tx,
    input wire logic [2:0] loop_rx_plus_below_minus,
    output logic loop1_tx_line,
    output logic loop2_tx_line,
    output logic [2:0] loop_port_rx,
    output logic loop1_tx_forced
);
    // inclusive window test used by every select but the station code
    function automatic logic in_window(input logic [15:0] a,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction : in_window

    // all registered state of the block
    typedef struct packed {
        logic sel1_n;
        logic sel2_n;
        logic sel3_n;
        logic bank1;          // first ram bank chosen
        logic bank2;          // second ram bank chosen
        logic bank3;          // third ram bank chosen
        logic rom;
        logic station_en;
        logic [7:0] station_q;
        logic to_cpu;
        logic xcvr_en;
        logic reg_sel;
        logic rw;
        logic enable;
        logic prev_phase;
        logic short_q;
        logic irq_n;
        logic loop2_tx;
        logic [2:0] rx;
    } isoad_state_t;

    isoad_state_t st_reg;
    isoad_state_t st_next;
    logic any_sel;

    // decode of the address bus, one process so all selects agree
    always_comb
    begin
        st_next = st_reg;
        // selects only while the processor marks the address valid
        st_next.sel1_n = !(cpu_valid_addr &&
            in_window(cpu_addr, isoad_pkg::LOOP1_LO,
                      isoad_pkg::LOOP1_HI));
        st_next.sel2_n = !(cpu_valid_addr &&
            in_window(cpu_addr, isoad_pkg::LOOP2_LO,
                      isoad_pkg::LOOP2_HI));
        st_next.sel3_n = !(cpu_valid_addr &&
            in_window(cpu_addr, isoad_pkg::LOOP3_LO,
                      isoad_pkg::LOOP3_HI));
        // windows are disjoint, so only one bank is ever chosen
        st_next.bank1 = cpu_valid_addr && in_window(cpu_addr,
            isoad_pkg::BANK1_LO, isoad_pkg::BANK1_HI);
        st_next.bank2 = cpu_valid_addr && in_window(cpu_addr,
            isoad_pkg::BANK2_LO, isoad_pkg::BANK2_HI);
        st_next.bank3 = cpu_valid_addr && in_window(cpu_addr,
            isoad_pkg::BANK3_LO, isoad_pkg::BANK3_HI);
        st_next.rom = cpu_valid_addr && in_window(cpu_addr,
            isoad_pkg::ROM_LO, isoad_pkg::ROM_HI);
        // station code only on a read of its single address
        st_next.station_en = cpu_valid_addr && cpu_read_write &&
            (cpu_addr == isoad_pkg::STATION_ADDR);
        // six switches, upper data bits read as zero
        st_next.station_q = st_next.station_en ?
            {2'h0, station_switches} : 8'h00;
        // transceiver faces the cpu on reads, memory on writes
        st_next.xcvr_en = st_next.bank1 || st_next.bank2 ||
            st_next.bank3 || st_next.rom;
        st_next.to_cpu = st_next.xcvr_en && cpu_read_write;
        // register select and direction passed to the ports
        st_next.reg_sel = cpu_addr[isoad_pkg::REG_SEL_BIT];
        st_next.rw = cpu_read_write;
        // port enable follows phase two so the transfer ends on its fall
        st_next.enable = cpu_phase_two;
        st_next.prev_phase = cpu_phase_two;
        // short strobe: phase two minus its first cycle, writes only
        st_next.short_q = cpu_phase_two && st_reg.prev_phase &&
            !cpu_read_write;
        // any port with a full receiver pulls the interrupt low
        st_next.irq_n = &port_irq_n;
        // loop two transmits as is; loop three has no transmit
        st_next.loop2_tx = loop2_port_tx;
        // comparator result: plus below minus gives a zero
        st_next.rx = ~loop_rx_plus_below_minus;
    end

    // register everything; reset deselects all and idles the lines high
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '{sel1_n: 1'b1, sel2_n: 1'b1, sel3_n: 1'b1,
                        bank1: 1'b0, bank2: 1'b0, bank3: 1'b0, rom: 1'b0,
                        station_en: 1'b0, station_q: 8'h00,
                        to_cpu: 1'b0, xcvr_en: 1'b0, reg_sel: 1'b0,
                        rw: 1'b1, enable: 1'b0, prev_phase: 1'b0,
                        short_q: 1'b0, irq_n: 1'b1, loop2_tx: 1'b1,
                        rx: 3'h7};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // loop one transmit goes through the idle watchdog
    isoad_watchdog #(
        .PERIOD_CYCLES(WATCHDOG_CYCLES)
    ) u_watchdog (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tx_data_in(loop1_port_tx),
        .tx_data_out(loop1_tx_line),
        .timed_out(loop1_tx_forced)
    );

    // output wiring from the state
    assign first_loop_select_n = st_reg.sel1_n;
    assign second_loop_select_n = st_reg.sel2_n;
    assign monitor_port_select_n = st_reg.sel3_n;
    assign ram_bank_one_select = st_reg.bank1;
    assign ram_bank_two_select = st_reg.bank2;
    assign ram_bank_three_select = st_reg.bank3;
    assign rom_select = st_reg.rom;
    assign station_code_read_enable = st_reg.station_en;
    assign station_data_out = st_reg.station_q;
    assign station_data_oe = st_reg.station_en;
    assign xcvr_to_cpu = st_reg.to_cpu;
    assign xcvr_enable = st_reg.xcvr_en;
    assign port_reg_select = st_reg.reg_sel;
    assign port_read_write = st_reg.rw;
    assign port_enable_strobe = st_reg.enable;
    assign short_write_strobe = st_reg.short_q;
    assign cpu_irq_n = st_reg.irq_n;
    assign loop2_tx_line = st_reg.loop2_tx;
    assign loop_port_rx = st_reg.rx;

    // helper for the unmapped check
    assign any_sel = !st_reg.sel1_n || !st_reg.sel2_n || !st_reg.sel3_n ||
        st_reg.bank1 || st_reg.bank2 || st_reg.bank3 || st_reg.rom ||
        st_reg.station_en;

    // a loop one address selects that port and not its neighbour
    AST_LOOP1_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_addr[15:8] == 8'h03) |=>
        (!first_loop_select_n && second_loop_select_n))
        else $error("loop one select wrong in its window");
    // a loop two address selects that port and not its neighbour
    AST_LOOP2_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_addr[15:8] == 8'h04) |=>
        (!second_loop_select_n && monitor_port_select_n))
        else $error("loop two select wrong in its window");
    // a monitor port address selects the receive-only port
    AST_MON_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_addr[15:8] == 8'h05) |=>
        (!monitor_port_select_n && first_loop_select_n))
        else $error("monitor select wrong in its window");
    // two memories on the bus at once would fight over the data
    AST_ONE_BANK: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $onehot0({ram_bank_one_select, ram_bank_two_select,
                  ram_bank_three_select, rom_select}))
        else $error("more than one memory select active");
    // the top ram window maps to the third bank
    AST_BANK_MAP: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_addr[15:13] == 3'h3) |=>
        ram_bank_three_select)
        else $error("third bank not chosen");
    // the whole upper half of the map is program store
    AST_ROM_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_addr[15]) |=> (rom_select && xcvr_enable))
        else $error("rom not selected in upper half");
    // a read of the code address puts the switches on the bus
    AST_STATION: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && cpu_read_write &&
        cpu_addr == isoad_pkg::STATION_ADDR) |=>
        (station_data_oe &&
        station_data_out == {2'h0, $past(station_switches)}))
        else $error("station code not driven on read");
    // a write never turns the switch buffer on
    AST_STN_WRITE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_valid_addr && !cpu_read_write) |=> !station_data_oe)
        else $error("station code driven during a write");
    // only six switches, so the top two data bits read zero
    AST_STN_WIDTH: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (station_data_out[7:6] == 2'h0))
        else $error("station code above six bits");
    // register select follows address bit 0; skip the reset edge
    AST_REG_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> (port_reg_select == $past(cpu_addr[0])))
        else $error("register select not from address bit 0");
    // transceiver faces the processor only for memory reads
    AST_XCVR_DIR: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (xcvr_enable |-> (xcvr_to_cpu == port_read_write)))
        else $error("transceiver direction wrong");
    // short strobe only inside a write phase two, after its first cycle
    AST_SHORT: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (short_write_strobe |-> (port_enable_strobe &&
            $past(port_enable_strobe) && !port_read_write)))
        else $error("short strobe outside write phase two");
    // addresses 1000-1FFF below the ram windows, or no valid address, select nothing
    AST_UNMAPPED: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_addr[15:12] == 4'h1 || !cpu_valid_addr) |=>
        (!any_sel && !xcvr_enable))
        else $error("select active for unmapped address");
    // the holes 0000-01FF below the station code and 0600-07FF above the port windows stay quiet
    AST_LOW_GAP: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cpu_addr[15:9] == 7'h00 || cpu_addr[15:9] == 7'h03) |=>
        (!any_sel && !xcvr_enable))
        else $error("select active in a low address hole");
    // receiver output inverts the comparator; skip the reset edge
    AST_RX: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) |->
        (loop_port_rx == ~$past(loop_rx_plus_below_minus)))
        else $error("receiver polarity wrong");
    // loop two transmit passes through a single register
    AST_TX2: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> (loop2_tx_line == $past(loop2_port_tx)))
        else $error("loop two transmit not passed on");
    // any port with a full receiver reaches the processor
    AST_IRQ: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (port_irq_n != 3'h7) |=> !cpu_irq_n)
        else $error("port interrupt not passed on");
    // with every port quiet the request is released
    AST_IRQ_IDLE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (port_irq_n == 3'h7) |=> cpu_irq_n)
        else $error("interrupt held with no port requesting");
endmodule : isoad_top
`default_nettype wire

// ==== verif/isoad_port_model.sv ====
// far-side model: serial port controllers beside the processor bus
`timescale 1ns/1ps
`default_nettype none
module isoad_port_model (
    // commands from the bench
    input wire logic [2:0] rx_full,
    input wire logic [1:0] tx_bits,
    // port side pins
    output logic [2:0] port_irq_n,
    output logic loop1_port_tx,
    output logic loop2_port_tx
);
    // a full receive buffer pulls that port's request low
    assign port_irq_n = ~rx_full;
    // loops 1 and 2 both transmit; loop 3 has no transmit line
    assign loop1_port_tx = tx_bits[0];
    assign loop2_port_tx = tx_bits[1];
endmodule : isoad_port_model
`default_nettype wire

// ==== verif/isolator_address_decode_tb.sv ====
// self-checking bench for the isolator address decode and loop glue
`timescale 1ns/1ps
`default_nettype none
module isolator_address_decode_tb;
    // short one-shot so the watchdog expires within a short run
    localparam int WD = 50;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_read_write = 1'b1;
    logic cpu_phase_two = 1'b0;
    logic cpu_valid_addr = 1'b0;
    logic [5:0] station_switches = 6'h00;
    logic [2:0] rx_full = 3'h0;
    logic [1:0] tx_bits = 2'h3;
    logic [2:0] loop_rx_plus_below_minus = 3'h0;
    logic [2:0] port_irq_n;
    logic loop1_port_tx, loop2_port_tx;
    logic sel1_n, sel2_n, sel3_n, bank1, bank2, bank3, rom, stat_en;
    logic [7:0] stat_data;
    logic stat_oe, to_cpu, xen, reg_sel, port_rw, port_en, short_wr;
    logic cpu_irq_n, tx1_line, tx2_line, tx1_forced;
    logic [2:0] port_rx;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // unit under test with a shortened one-shot period
    isoad_top #(.WATCHDOG_CYCLES(WD)) DUT (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .cpu_addr(cpu_addr),
        .cpu_read_write(cpu_read_write), .cpu_phase_two(cpu_phase_two),
        .cpu_valid_addr(cpu_valid_addr), .station_switches(station_switches),
        .first_loop_select_n(sel1_n), .second_loop_select_n(sel2_n),
        .monitor_port_select_n(sel3_n), .ram_bank_one_select(bank1),
        .ram_bank_two_select(bank2), .ram_bank_three_select(bank3),
        .rom_select(rom), .station_code_read_enable(stat_en),
        .station_data_out(stat_data), .station_data_oe(stat_oe),
        .xcvr_to_cpu(to_cpu), .xcvr_enable(xen), .port_reg_select(reg_sel),
        .port_read_write(port_rw), .port_enable_strobe(port_en),
        .short_write_strobe(short_wr), .port_irq_n(port_irq_n),
        .cpu_irq_n(cpu_irq_n), .loop1_port_tx(loop1_port_tx),
        .loop2_port_tx(loop2_port_tx),
        .loop_rx_plus_below_minus(loop_rx_plus_below_minus),
        .loop1_tx_line(tx1_line), .loop2_tx_line(tx2_line),
        .loop_port_rx(port_rx), .loop1_tx_forced(tx1_forced));
    // far-side serial port controllers
    isoad_port_model PORTS (.rx_full(rx_full), .tx_bits(tx_bits),
        .port_irq_n(port_irq_n), .loop1_port_tx(loop1_port_tx),
        .loop2_port_tx(loop2_port_tx));
    // 200 MHz clock
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // one comparison, reported at once on mismatch
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // inclusive window test, gated by address valid
    function automatic logic in_rng(logic v, logic [15:0] a,
        logic [15:0] lo, logic [15:0] hi);
        return v && a >= lo && a <= hi;
    endfunction : in_rng
    // one bus cycle, outputs checked one clock later
    task automatic decode(input logic [15:0] a, input logic rw,
        input logic v);
        logic mem;
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_read_write = rw;
        cpu_valid_addr = v;
        @(negedge sys_clk);
        mem = in_rng(v, a, 16'h2000, 16'hffff);
        // direction only matters while the transceiver is on
        check({4'h0, sel1_n, sel2_n, sel3_n, bank1, bank2, bank3, rom,
            stat_en,
            xen, to_cpu & xen, reg_sel, port_rw},
            {4'h0, ~in_rng(v, a, 16'h0300, 16'h03ff),
            ~in_rng(v, a, 16'h0400, 16'h04ff),
            ~in_rng(v, a, 16'h0500, 16'h05ff),
            in_rng(v, a, 16'h2000, 16'h3fff), in_rng(v, a, 16'h4000, 16'h5fff),
            in_rng(v, a, 16'h6000, 16'h7fff), in_rng(v, a, 16'h8000, 16'hffff),
            rw && in_rng(v, a, 16'h0200, 16'h0200), mem, mem && rw, a[0], rw});
    endtask : decode
    // every window edge and gap, read and write with valid high; one read at 300 with valid low
    task automatic test_decode;
        logic [15:0] tab [19] = '{16'h0000, 16'h0200, 16'h02ff, 16'h0300,
            16'h03ff, 16'h0400, 16'h04ff, 16'h0500, 16'h05ff, 16'h0600,
            16'h1fff, 16'h2000, 16'h3fff, 16'h4000, 16'h5fff, 16'h6000,
            16'h7fff, 16'h8000, 16'hffff};
        for (int i = 0; i < 19; i++)
        begin
            decode(tab[i], 1'b1, 1'b1);
            decode(tab[i], 1'b0, 1'b1);
        end
        decode(16'h0300, 1'b1, 1'b0);
    endtask : test_decode
    // switch code read at 200; a write there must not drive the bus
    task automatic test_station;
        logic [5:0] codes [3] = '{6'h00, 6'h2a, 6'h3f};
        for (int i = 0; i < 3; i++)
        begin
            station_switches = codes[i];
            decode(16'h0200, 1'b1, 1'b1);
            check({7'h0, stat_oe, stat_data}, {8'h01, 2'b00, codes[i]});
        end
        decode(16'h0200, 1'b0, 1'b1);
        check({7'h0, stat_oe, stat_data}, 16'h0000);
    endtask : test_station
    // short strobe skips the first phase-two cycle and only on writes
    task automatic test_strobe(input logic rw);
        @(negedge sys_clk);
        cpu_read_write = rw;
        cpu_phase_two = 1'b1;
        @(negedge sys_clk);
        check({14'h0, port_en, short_wr}, 16'h0002);
        @(negedge sys_clk);
        check({14'h0, port_en, short_wr}, {15'h1, ~rw});
        cpu_phase_two = 1'b0;
        @(negedge sys_clk);
        check({14'h0, port_en, short_wr}, 16'h0000);
    endtask : test_strobe
    // each port request reaches the merged interrupt, receivers invert
    task automatic test_ports;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge sys_clk);
            rx_full = i[2:0];
            loop_rx_plus_below_minus = i[2:0];
            tx_bits[1] = i[0];
            @(negedge sys_clk);
            check({12'h0, cpu_irq_n, port_rx},
                {12'h0, i == 0, ~i[2:0]});
            check({15'h0, tx2_line}, {15'h0, i[0]});
        end
    endtask : test_ports
    // idle after reset, release on traffic, retrigger, then expiry
    task automatic test_watchdog;
        check({14'h0, tx1_forced, tx1_line}, 16'h0003);
        @(negedge sys_clk);
        tx_bits[0] = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({14'h0, tx1_forced, tx1_line}, 16'h0000);
        repeat (27) @(negedge sys_clk);
        tx_bits[0] = 1'b1;
        repeat (3) @(negedge sys_clk);
        tx_bits[0] = 1'b0;
        // last change lands on the next edge; expiry is WD edges later,
        // so look one cycle before and one cycle after that edge
        repeat (WD) @(negedge sys_clk);
        check({14'h0, tx1_forced, tx1_line}, 16'h0000);
        @(negedge sys_clk);
        check({14'h0, tx1_forced, tx1_line}, 16'h0003);
    endtask : test_watchdog
    // verdict and end of run
    task automatic tally_and_finish;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // hang guard: run needs well under a thousand cycles
    initial
    begin
        forever
        begin
            @(posedge sys_clk);
            cycles++;
            if (cycles == 3000)
            begin
                errors++;
                $display("ERROR at %0t: run did not finish", $time);
                tally_and_finish();
            end
        end
    end
    // main sequence
    initial
    begin
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        test_watchdog();
        test_decode();
        test_station();
        test_strobe(1'b0);
        test_strobe(1'b1);
        test_ports();
        tally_and_finish();
    end
endmodule : isolator_address_decode_tb
`default_nettype wire
